// ===== verilog/rps_pkg.sv
// Constants and types for the remote power state controller
package rps_pkg;
   localparam int CLK_PERIOD_PS    = 4000;
   localparam int TICK_NS          = 1000000;
   localparam int TICK_CYCLES      = (TICK_NS * 1000) / CLK_PERIOD_PS;
   localparam int MS_W             = 14;
   localparam int ACT_POLL_MS      = 10;
   localparam int IDLE_POLL_MS     = 125;
   localparam int SLEEP_POLL_MS    = 250;
   localparam int BATT_MS          = 3000;
   localparam int ACT_TIMEOUT_MS   = 3000;
   localparam int IDLE_TIMEOUT_MS  = 10000;
   localparam int CONN_INTERVAL_MS = 10;
   localparam int PERIPH_LATENCY   = 100;
   localparam int LOW_BATT_MV      = 2000;
   localparam int CRIT_BATT_MV     = 1800;
   localparam int SLOW_BLINK_MS    = 500;
   localparam int BLINK_WRAP_MS    = 1000;
   localparam int FAST_BLINK_BIT   = 6;
   localparam int LINK_ALERT_MS    = 2000;

   typedef enum logic [4:0] {
      RPS_INIT   = 5'h01,
      RPS_ACTIVE = 5'h02,
      RPS_IDLE   = 5'h04,
      RPS_SLEEP  = 5'h08,
      RPS_SHUT   = 5'h10
   } rps_state_e;
endpackage : rps_pkg

// ===== verilog/rps_power_ctrl.sv
// Five-state power sequencer for a battery remote control
// Operation
// - After power-on enter init, initialise subsystems, then go active when done.
// - In active, sample every input subsystem once each 10 ms.
// - Active and connected, forward collected input data to the host.
// - Active to idle after 3 s without user activity.
// - Idle polls trackpad each 125 ms; other sources wake by interrupt.
// - Idle and sleep keep link at 10 ms interval, latency 100.
// - Any user activity in idle returns to active.
// - Idle to sleep after 10 s without user activity.
// - Sleep polls trackpad each 250 ms.
// - In sleep an interrupt from other sources wakes to active.
// - Measure battery every 3 s in every state but shutdown.
// - Battery near 2.0 V starts slow red LED blinking.
// - Battery below 1.8 V in active, idle or sleep forces shutdown.
// - Shutdown disables all subsystems and radio, processor to stop mode.
// - Shutdown is left only by removing supply power.
// - Unconnected, advertise to reconnect and send an infrared TV command.
// - After link loss, user activity triggers fast red LED blinking.
// - Outside init and shutdown, processor goes to deep sleep whenever no work is pending.
`timescale 1ns/1ps
module rps_power_ctrl #(
   parameter int TICK_CYCLES = rps_pkg::TICK_CYCLES,
   parameter int MV_W        = 12,
   parameter int DATA_W      = 32
) (
   // Clock and reset
   input  wire logic                clock_i,
   input  wire logic                rst_i,
   // Input subsystems
   input  wire logic                init_done_i,
   input  wire logic                btn_irq_i,
   input  wire logic                trackpad_touch_i,
   input  wire logic [DATA_W-1:0]   input_data_i,
   // Battery monitor
   input  wire logic                batt_valid_i,
   input  wire logic [MV_W-1:0]     batt_mv_i,
   // Radio link status
   input  wire logic                link_up_i,
   // State and subsystem control
   output      rps_pkg::rps_state_e state_o,
   output      logic                subsys_init_o,
   output      logic                subsys_en_o,
   output      logic                radio_en_o,
   output      logic                irq_wake_en_o,
   output      logic                poll_o,
   output      logic                tp_poll_o,
   output      logic                batt_meas_o,
   // Host report and link setup
   output      logic                report_send_o,
   output      logic [DATA_W-1:0]   report_data_o,
   output      logic [7:0]          conn_interval_o,
   output      logic [7:0]          periph_latency_o,
   output      logic                advertise_o,
   output      logic                ir_send_o,
   // Indicators and processor
   output      logic                red_led_o,
   output      logic                cpu_deep_sleep_o,
   output      logic                cpu_stop_o
);
   import rps_pkg::*;

   rps_state_e        state_q, state_d;
   logic [31:0]       div_q;
   logic [MS_W-1:0]   poll_ms_q, idle_ms_q, batt_ms_q, blink_ms_q, alert_ms_q;
   logic [1:0]        s1_q, s2_q, s3_q, stab_q;
   logic              meas_pend_q, low_q, had_link_q, lost_q, alert_q;

   // Time base of 1 ms keeps every timer narrow
   wire tick      = (div_q == 32'(TICK_CYCLES - 1));
   wire st_init   = (state_q == RPS_INIT);
   wire st_act    = (state_q == RPS_ACTIVE);
   wire st_idle   = (state_q == RPS_IDLE);
   wire st_sleep  = (state_q == RPS_SLEEP);
   wire st_shut   = (state_q == RPS_SHUT);
   wire st_run    = st_act | st_idle | st_sleep;
   wire st_low    = st_idle | st_sleep;
   wire chg       = (state_d != state_q);

   // Pin inputs, three flops, accepted when stages two and three agree
   wire [1:0] raw = {trackpad_touch_i, btn_irq_i};
   for (genvar g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clock_i) begin
         if (rst_i) begin
            s1_q[g]   <= 1'b0;
            s2_q[g]   <= 1'b0;
            s3_q[g]   <= 1'b0;
            stab_q[g] <= 1'b0;
         end else begin
            s1_q[g] <= raw[g];
            s2_q[g] <= s1_q[g];
            s3_q[g] <= s2_q[g];
            if (s2_q[g] == s3_q[g]) begin
               stab_q[g] <= s3_q[g];
            end
         end
      end
   end
   wire irq_act  = stab_q[0];
   wire tp_touch = stab_q[1];

   // Poll period per state
   wire [MS_W-1:0] poll_last = st_act  ? MS_W'(ACT_POLL_MS - 1) :
                               st_idle ? MS_W'(IDLE_POLL_MS - 1) :
                                         MS_W'(SLEEP_POLL_MS - 1);
   wire poll_hit = tick & st_run & (poll_ms_q == poll_last);

   // Active samples all sources; low-power states take interrupts at once
   wire act_seen = st_act ? (poll_hit & (irq_act | tp_touch)) :
                   st_low & (irq_act | (poll_hit & tp_touch));

   wire [MS_W-1:0] idle_last = st_act ? MS_W'(ACT_TIMEOUT_MS - 1) :
                                        MS_W'(IDLE_TIMEOUT_MS - 1);
   wire idle_hit = tick & (st_act | st_idle) & (idle_ms_q == idle_last);

   wire batt_hit = tick & ~st_shut & (batt_ms_q == MS_W'(BATT_MS - 1));
   wire batt_in  = batt_valid_i & meas_pend_q;
   wire crit     = batt_in & (batt_mv_i < MV_W'(CRIT_BATT_MV));
   wire low_now  = batt_mv_i <= MV_W'(LOW_BATT_MV);
   wire link_act = act_seen & lost_q & ~link_up_i;
   wire rpt      = st_act & link_up_i & act_seen;
   wire busy     = poll_hit | batt_hit | act_seen | meas_pend_q | batt_valid_i;

   always_comb begin
      state_d = state_q;
      case (state_q)
         RPS_INIT: begin
            if (init_done_i) state_d = RPS_ACTIVE;
         end
         RPS_ACTIVE: begin
            if (crit) state_d = RPS_SHUT;
            else if (idle_hit) state_d = RPS_IDLE;
         end
         RPS_IDLE: begin
            if (crit) state_d = RPS_SHUT;
            else if (act_seen) state_d = RPS_ACTIVE;
            else if (idle_hit) state_d = RPS_SLEEP;
         end
         RPS_SLEEP: begin
            if (crit) state_d = RPS_SHUT;
            else if (act_seen) state_d = RPS_ACTIVE;
         end
         RPS_SHUT: begin
            state_d = RPS_SHUT;
         end
         default: begin
            state_d = RPS_INIT;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_q <= RPS_INIT;
         div_q   <= 32'h0;
      end else begin
         state_q <= state_d;
         div_q   <= tick ? 32'h0 : div_q + 32'h1;
      end
   end

   // Millisecond timers; a state change restarts poll and inactivity
   always_ff @(posedge clock_i) begin
      if (rst_i || chg) begin
         poll_ms_q <= '0;
         idle_ms_q <= '0;
      end else begin
         if (tick) poll_ms_q <= (poll_ms_q == poll_last) ? '0 : poll_ms_q + 1'b1;
         if (act_seen) idle_ms_q <= '0;
         else if (tick) idle_ms_q <= idle_ms_q + 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         batt_ms_q   <= '0;
         blink_ms_q  <= '0;
         meas_pend_q <= 1'b0;
         low_q       <= 1'b0;
      end else begin
         if (tick) batt_ms_q <= batt_hit ? '0 : batt_ms_q + 1'b1;
         if (tick) begin
            blink_ms_q <= (blink_ms_q == MS_W'(BLINK_WRAP_MS - 1)) ? '0 : blink_ms_q + 1'b1;
         end
         // Request wins over a reading arriving in the same cycle
         if (batt_hit) meas_pend_q <= 1'b1;
         else if (batt_in) meas_pend_q <= 1'b0;
         if (batt_in) low_q <= low_now;
      end
   end

   // Link loss tracking; alert set wins over its own timeout
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         had_link_q <= 1'b0;
         lost_q     <= 1'b0;
         alert_q    <= 1'b0;
         alert_ms_q <= '0;
      end else begin
         if (link_up_i) had_link_q <= 1'b1;
         if (link_up_i) lost_q <= 1'b0;
         else if (had_link_q) lost_q <= 1'b1;
         if (link_act) begin
            alert_q    <= 1'b1;
            alert_ms_q <= '0;
         end else if (alert_q && tick) begin
            alert_ms_q <= alert_ms_q + 1'b1;
            if (alert_ms_q == MS_W'(LINK_ALERT_MS - 1)) alert_q <= 1'b0;
         end
      end
   end

   // Outputs follow the next state so shutdown takes effect on entry
   wire d_shut = (state_d == RPS_SHUT);
   wire d_init = (state_d == RPS_INIT);
   wire d_low  = (state_d == RPS_IDLE) | (state_d == RPS_SLEEP);
   wire slow   = blink_ms_q < MS_W'(SLOW_BLINK_MS);
   wire fast   = blink_ms_q[FAST_BLINK_BIT];
   wire led_d  = ~d_shut & (alert_q ? fast : (low_q & slow));

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_o          <= RPS_INIT;
         subsys_init_o    <= 1'b0;
         subsys_en_o      <= 1'b0;
         radio_en_o       <= 1'b0;
         irq_wake_en_o    <= 1'b0;
         poll_o           <= 1'b0;
         tp_poll_o        <= 1'b0;
         batt_meas_o      <= 1'b0;
         report_send_o    <= 1'b0;
         report_data_o    <= '0;
         conn_interval_o  <= 8'h00;
         periph_latency_o <= 8'h00;
         advertise_o      <= 1'b0;
         ir_send_o        <= 1'b0;
         red_led_o        <= 1'b0;
         cpu_deep_sleep_o <= 1'b0;
         cpu_stop_o       <= 1'b0;
      end else begin
         state_o          <= state_d;
         subsys_init_o    <= d_init;
         subsys_en_o      <= ~d_shut;
         radio_en_o       <= ~d_shut;
         irq_wake_en_o    <= d_low;
         poll_o           <= poll_hit & st_act;
         tp_poll_o        <= poll_hit;
         batt_meas_o      <= batt_hit;
         report_send_o    <= rpt;
         if (rpt) report_data_o <= input_data_i;
         conn_interval_o  <= d_shut ? 8'h00 : 8'(CONN_INTERVAL_MS);
         periph_latency_o <= d_low ? 8'(PERIPH_LATENCY) : 8'h00;
         advertise_o      <= ~d_shut & ~d_init & ~link_up_i;
         ir_send_o        <= act_seen & ~link_up_i & ~crit;
         red_led_o        <= led_d;
         cpu_deep_sleep_o <= ~d_shut & ~d_init & ~busy;
         cpu_stop_o       <= d_shut;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_crit_run;
      crit && st_run;
   endsequence
   sequence s_shut_entered;
      state_q == RPS_SHUT && cpu_stop_o && !radio_en_o && !subsys_en_o;
   endsequence

   property p_init_exit;
      st_init && init_done_i |=> state_q == RPS_ACTIVE && !subsys_init_o;
   endproperty
   a_init_exit: assert property (p_init_exit) else $error("init exit");

   property p_active_poll;
      st_act && poll_hit |=> poll_o && tp_poll_o;
   endproperty
   a_active_poll: assert property (p_active_poll) else $error("active poll");

   property p_report;
      report_send_o |-> $past(st_act) && $past(link_up_i) &&
                        report_data_o == $past(input_data_i);
   endproperty
   a_report: assert property (p_report) else $error("report");

   property p_to_idle;
      st_act && idle_hit && !crit |=> state_q == RPS_IDLE && irq_wake_en_o;
   endproperty
   a_to_idle: assert property (p_to_idle) else $error("idle entry");

   property p_link_params;
      st_low |-> irq_wake_en_o && periph_latency_o == 8'(PERIPH_LATENCY) &&
                 conn_interval_o == 8'(CONN_INTERVAL_MS);
   endproperty
   a_link_params: assert property (p_link_params) else $error("link params");

   property p_wake;
      st_low && act_seen && !crit |=> state_q == RPS_ACTIVE;
   endproperty
   a_wake: assert property (p_wake) else $error("wake");

   property p_crit;
      s_crit_run |=> s_shut_entered;
   endproperty
   a_crit: assert property (p_crit) else $error("critical battery");

   property p_shut_stays;
      st_shut |=> st_shut && cpu_stop_o && !batt_meas_o;
   endproperty
   a_shut_stays: assert property (p_shut_stays) else $error("left shutdown");

   property p_restart;
      act_seen && !chg |=> idle_ms_q == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("timer restart");
endmodule : rps_power_ctrl

// ===== tb/rps_batt_model.sv
// Behavioural battery monitor answering the controller's measurement requests
`timescale 1ns/1ps
module rps_batt_model (
   // Clock and request
   input  wire logic        clock_i,
   input  wire logic        meas_i,
   // Reading chosen by the bench
   input  wire logic [31:0] dly_i,
   input  wire logic [11:0] mv_i,
   // Reading to the controller
   output logic             valid_o,
   output logic [11:0]      mv_o
);
   initial begin
      valid_o = 1'b0;
      mv_o = 12'h000;
   end
   // One reading per request, after a delay the bench sets
   // Bus shows junk between readings so a stale value cannot pass
   always begin
      @(posedge clock_i);
      if (meas_i === 1'b1) begin
         repeat (dly_i) @(posedge clock_i);
         valid_o <= 1'b1;
         mv_o <= mv_i;
         @(posedge clock_i);
         valid_o <= 1'b0;
         mv_o <= ~mv_i;
      end
   end
endmodule : rps_batt_model

// ===== tb/testbench.sv
// Self-checking bench for the remote power state controller
`timescale 1ns/1ps
module testbench;
   import rps_pkg::*;
   localparam int TK = 4;
   logic        clock_i, rst_i, init_done_i, btn_irq_i, trackpad_touch_i, batt_valid_i;
   logic        link_up_i, subsys_init_o, subsys_en_o, radio_en_o, irq_wake_en_o, poll_o;
   logic        tp_poll_o, batt_meas_o, report_send_o, advertise_o, ir_send_o, red_led_o;
   logic        cpu_deep_sleep_o, cpu_stop_o, ds_seen;
   logic [31:0] input_data_i, report_data_o, d_prev, dly;
   logic [11:0] batt_mv_i, mv;
   logic [7:0]  conn_interval_o, periph_latency_o;
   rps_state_e  state_o;
   int          n_fail, total_checks, cyc, n_rep, n_ir, n_red, t0, r0;
   int          last[3], gap[3];
   int          seed = 32'h838a;
   wire logic [2:0] pl = {batt_meas_o, tp_poll_o, poll_o};

   rps_power_ctrl #(.TICK_CYCLES(TK)) rps_power_ctrl_i (
      .clock_i(clock_i), .rst_i(rst_i), .init_done_i(init_done_i),
      .btn_irq_i(btn_irq_i), .trackpad_touch_i(trackpad_touch_i), .input_data_i(input_data_i),
      .batt_valid_i(batt_valid_i), .batt_mv_i(batt_mv_i), .link_up_i(link_up_i),
      .state_o(state_o), .subsys_init_o(subsys_init_o), .subsys_en_o(subsys_en_o),
      .radio_en_o(radio_en_o), .irq_wake_en_o(irq_wake_en_o), .poll_o(poll_o),
      .tp_poll_o(tp_poll_o), .batt_meas_o(batt_meas_o), .report_send_o(report_send_o),
      .report_data_o(report_data_o), .conn_interval_o(conn_interval_o),
      .periph_latency_o(periph_latency_o), .advertise_o(advertise_o), .ir_send_o(ir_send_o),
      .red_led_o(red_led_o), .cpu_deep_sleep_o(cpu_deep_sleep_o), .cpu_stop_o(cpu_stop_o));
   rps_batt_model rps_batt_model_i (.clock_i(clock_i), .meas_i(batt_meas_o), .dly_i(dly),
      .mv_i(mv), .valid_o(batt_valid_i), .mv_o(batt_mv_i));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test();
      if (n_fail == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge clock_i);
   endtask : cyc_wait
   // Bounded wait on the state, then compare it
   task automatic wait_st(input rps_state_e s, input int lim);
      int n;
      n = 0;
      while (state_o !== s && n < lim) begin
         @(posedge clock_i);
         n++;
      end
      #1 chk(state_o, s);
   endtask : wait_st

   always #2 clock_i = ~clock_i;
   // Model side: pulse spacing, report data one cycle late, LED and IR counts
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      d_prev <= input_data_i;
      input_data_i <= $random(seed);
      if (report_send_o === 1'b1) begin
         n_rep++;
         chk(report_data_o, d_prev);
      end
      for (int k = 0; k < 3; k++) begin
         if (pl[k] === 1'b1) begin
            gap[k] <= cyc - last[k];
            last[k] <= cyc;
         end
      end
      n_ir <= n_ir + int'(ir_send_o === 1'b1);
      n_red <= n_red + int'(red_led_o === 1'b1);
      if (state_o === RPS_IDLE && cpu_deep_sleep_o === 1'b1) ds_seen <= 1'b1;
      if (cyc > 99000) begin
         n_fail++;
         finish_test();
      end
   end

   initial begin
      clock_i = 1'b0;
      rst_i = 1'b1;
      init_done_i = 1'b0;
      btn_irq_i = 1'b0;
      trackpad_touch_i = 1'b0;
      link_up_i = 1'b0;
      input_data_i = 32'h0;
      ds_seen = 1'b0;
      mv = 12'hbb8;
      dly = 32'h0;
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      cyc_wait(2);
      #1 chk(subsys_init_o, 1'b1);
      @(posedge clock_i);
      init_done_i <= 1'b1;
      link_up_i <= 1'b1;
      @(posedge clock_i);
      #1 chk(state_o, RPS_ACTIVE);
      cyc_wait(100);
      chk(gap[0], ACT_POLL_MS * TK);
      chk({conn_interval_o, periph_latency_o}, {8'(CONN_INTERVAL_MS), 8'h00});
      btn_irq_i <= 1'b1;
      cyc_wait(200);
      btn_irq_i <= 1'b0;
      t0 = cyc;
      chk({n_rep > 3, advertise_o}, 2'b10);
      // Timeout counts from the last activity, not from entry
      wait_st(RPS_IDLE, 13000);
      chk(cyc - t0 >= ACT_TIMEOUT_MS * TK - 50 && cyc - t0 <= ACT_TIMEOUT_MS * TK + 20, 1);
      chk({irq_wake_en_o, periph_latency_o}, {1'b1, 8'(PERIPH_LATENCY)});
      cyc_wait(1100);
      chk(gap[1], IDLE_POLL_MS * TK);
      chk(ds_seen, 1'b1);
      trackpad_touch_i <= 1'b1;
      wait_st(RPS_ACTIVE, 600);
      @(posedge clock_i);
      trackpad_touch_i <= 1'b0;
      wait_st(RPS_IDLE, 13000);
      t0 = cyc;
      wait_st(RPS_SLEEP, 41000);
      chk(cyc - t0 >= IDLE_TIMEOUT_MS * TK - 8 && cyc - t0 <= IDLE_TIMEOUT_MS * TK + 12, 1);
      chk(periph_latency_o, 8'(PERIPH_LATENCY));
      cyc_wait(2100);
      chk(gap[1], SLEEP_POLL_MS * TK);
      chk(gap[2], BATT_MS * TK);
      btn_irq_i <= 1'b1;
      wait_st(RPS_ACTIVE, 20);
      @(posedge clock_i);
      btn_irq_i <= 1'b0;
      link_up_i <= 1'b0;
      chk(n_red, 0);
      cyc_wait(50);
      chk(advertise_o, 1'b1);
      btn_irq_i <= 1'b1;
      cyc_wait(600);
      btn_irq_i <= 1'b0;
      chk({n_ir > 0, n_red > 0}, 2'b11);
      // Slow replies; alert has run out before the blink window
      mv <= 12'h76c;
      dly <= 32'h40;
      cyc_wait(12600);
      r0 = n_red;
      cyc_wait(BLINK_WRAP_MS * TK);
      chk(n_red - r0, SLOW_BLINK_MS * TK);
      mv <= 12'h6a4;
      wait_st(RPS_SHUT, 12300);
      #1 chk({cpu_stop_o, subsys_en_o, radio_en_o, advertise_o, conn_interval_o}, 12'h800);
      @(posedge clock_i);
      btn_irq_i <= 1'b1;
      cyc_wait(100);
      chk(state_o, RPS_SHUT);
      finish_test();
   end
endmodule : testbench
